// ---- bench/dci_tb.sv ----
// Self-checking bench for the DMA channel interrupt status block
`default_nettype none
module testbench
  import dci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr_en, rd_en, irq;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata;
  logic [NCH-1:0][1:0] chan_width, src_addr_lo, tgt_addr_lo;
  logic [NCH-1:0] chk_valid, tfr_done, exp_mis;
  int n_errors, n_checks;

  dci_irq_status dci_irq_status_inst (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .irq(irq), .chan_width(chan_width),
    .src_addr_lo(src_addr_lo), .tgt_addr_lo(tgt_addr_lo),
    .chk_valid(chk_valid), .tfr_done(tfr_done));

  // ****************************************
  // Clock, checks and bus tasks
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  // One-cycle write strobe, a gap cycle follows
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic final_report;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog, far beyond the seventy or so cycles the tests need
  initial
  begin
    #200000;
    n_errors++;
    final_report;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = '0;
    wdata = '0;
    chan_width = '0;
    src_addr_lo = '0;
    tgt_addr_lo = '0;
    chk_valid = '0;
    tfr_done = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(SUMMARY_OFS, 32'h0);
    rd(MISALIGN_OFS, FLAGS_RST);
    rd(TFR_OFS, 32'h0);
    rd(MIS_EN_OFS, EN_RST);
    rd(TFR_EN_OFS, EN_RST);
    check({31'h0, irq}, 32'h0);
    // Every width code against every low address pattern
    @(posedge clk);
    for (int c = 0; c < NCH; c++)
    begin
      chan_width[c] <= 2'(c >> 2);
      if (c >= 16)
        tgt_addr_lo[c] <= 2'(c);
      else
        src_addr_lo[c] <= 2'(c);
      exp_mis[c] = (2'(c >> 2) == WIDTH_WORD && 2'(c) != 2'h0) ||
        (2'(c >> 2) == WIDTH_HALF && c[0]);
    end
    @(posedge clk) chk_valid <= '1;
    @(posedge clk) chk_valid <= '0;
    rd(MISALIGN_OFS, exp_mis);
    rd(SUMMARY_OFS, exp_mis);
    check({31'h0, irq}, 32'h1);
    // Masking hides the flags from summary and irq
    wr(MIS_EN_OFS, 32'h0);
    rd(SUMMARY_OFS, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(MIS_EN_OFS, EN_RST);
    // Summary is read-only; partial clear keeps the rest
    wr(SUMMARY_OFS, 32'hffff_ffff);
    wr(MISALIGN_OFS, 32'h0000_ffff);
    rd(MISALIGN_OFS, exp_mis & 32'hffff_0000);
    rd(SUMMARY_OFS, exp_mis & 32'hffff_0000);
    // Addresses still off but not checked, so no new flags
    wr(MISALIGN_OFS, 32'hffff_ffff);
    rd(MISALIGN_OFS, 32'h0);
    // Transfer-complete feeds the summary at the edge channels
    @(posedge clk) tfr_done <= 32'h8000_0001;
    @(posedge clk) tfr_done <= '0;
    rd(TFR_OFS, 32'h8000_0001);
    rd(SUMMARY_OFS, 32'h8000_0001);
    wr(TFR_EN_OFS, 32'h8000_0000);
    rd(SUMMARY_OFS, 32'h8000_0000);
    rd(12'h040, 32'h0);
    wr(TFR_OFS, 32'hffff_ffff);
    rd(SUMMARY_OFS, 32'h0);
    // Mid-run reset drops set flags and brings the masks back
    @(posedge clk) chk_valid <= '1;
    @(posedge clk) chk_valid <= '0;
    rd(MISALIGN_OFS, exp_mis);
    check({31'h0, irq}, 32'h1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h0);
    @(posedge clk) rst_n <= 1'b1;
    rd(MISALIGN_OFS, FLAGS_RST);
    rd(TFR_EN_OFS, EN_RST);
    rd(SUMMARY_OFS, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    final_report;
  end
endmodule
`default_nettype wire

// ---- logic/dci_align_check.sv ----
// Per-channel address alignment checker
`default_nettype none
module dci_align_check
  import dci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  dci_chk_if.calc chk
);

  // ****************************************
  // Alignment decode
  // ****************************************

  // Low address bits against item width; reserved code acts as byte
  function automatic logic bad_align(input logic [1:0] w,
                                     input logic [1:0] lo);
    logic r;
    r = 1'b0;
    case (w)
      WIDTH_WORD: r = (lo != 2'b00);
      WIDTH_HALF: r = lo[0];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // Source or target misaligned raises the channel's condition
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      chk.misalign[i] = bad_align(chk.width[i], chk.src_lo[i]) |
                        bad_align(chk.width[i], chk.tgt_lo[i]);
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  // Every channel is watched, so any width code on any channel is seen
  for (genvar i = 0; i < NCH; i++)
  begin : g_align_chk
    a_word_align: assert property (@(posedge clk) disable iff (!rst_n)
      (chk.width[i] == WIDTH_WORD)
        |-> (chk.misalign[i] ==
             ((chk.src_lo[i] != 2'b00) || (chk.tgt_lo[i] != 2'b00))))
      else $error("word alignment wrong");

    a_half_align: assert property (@(posedge clk) disable iff (!rst_n)
      (chk.width[i] == WIDTH_HALF)
        |-> (chk.misalign[i] == (chk.src_lo[i][0] | chk.tgt_lo[i][0])))
      else $error("half word alignment wrong");

    a_byte_free: assert property (@(posedge clk) disable iff (!rst_n)
      ((chk.width[i] == WIDTH_BYTE) || (chk.width[i] == WIDTH_RSVD))
        |-> !chk.misalign[i])
      else $error("byte width flagged as misaligned");
  end

endmodule
`default_nettype wire

// ---- logic/dci_chk_if.sv ----
// Bundle between the status block and its alignment checker
`default_nettype none
interface dci_chk_if;
  import dci_pkg::*;
  logic [NCH-1:0][1:0] width;
  logic [NCH-1:0][1:0] src_lo;
  logic [NCH-1:0][1:0] tgt_lo;
  logic [NCH-1:0] misalign;
  modport calc (input width, input src_lo, input tgt_lo, output misalign);
  modport user (output width, output src_lo, output tgt_lo, input misalign);
endinterface
`default_nettype wire

// ---- logic/dci_irq_status.sv ----
// DMA channel interrupt status: misalign flags, summary word, irq
//
// Added by the designer: strobed register access.
`default_nettype none

// Contract
// - A channel's flag rises while chk_valid is high and its source or target is off its width.
// - A misalign flag reads 1 while its address error is pending, else 0.
// - Flag n sits at bit n, resets to zero and clears on a written one.
// - Read-only summary at 0x020 has bit n for channel n, reset zero.
// - Each summary bit is the live OR of its channel's unmasked flags.
// - Word needs both low address bits zero, half word needs bit 0 zero.
// - Width code 1 is byte, 2 is half word and 3 is word.
module dci_irq_status
  import dci_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic irq,
  input wire logic [NCH-1:0][1:0] chan_width,
  input wire logic [NCH-1:0][1:0] src_addr_lo,
  input wire logic [NCH-1:0][1:0] tgt_addr_lo,
  input wire logic [NCH-1:0] chk_valid,
  input wire logic [NCH-1:0] tfr_done
);

  // ****************************************
  // Alignment checker
  // ****************************************

  dci_chk_if chk ();

  // Channel settings go straight to the checker
  assign chk.width = chan_width;
  assign chk.src_lo = src_addr_lo;
  assign chk.tgt_lo = tgt_addr_lo;

  dci_align_check u_chk (
    .clk(clk),
    .rst_n(rst_n),
    .chk(chk)
  );

  // ****************************************
  // Register decode
  // ****************************************

  logic [NCH-1:0] mis_flags;
  logic [NCH-1:0] tfr_flags;
  logic [NCH-1:0] mis_en;
  logic [NCH-1:0] tfr_en;
  wire logic wr_mis;
  wire logic wr_tfr;
  wire logic wr_mis_en;
  wire logic wr_tfr_en;
  wire logic [NCH-1:0] mis_set;
  wire logic [NCH-1:0] summary;
  wire logic [NCH-1:0] next_mis_flags;
  wire logic [NCH-1:0] next_tfr_flags;
  wire logic [31:0] rd_sel;
  wire logic rd_hit;

  // Write strobes per register
  assign wr_mis = wr_en && (addr == MISALIGN_OFS);
  assign wr_tfr = wr_en && (addr == TFR_OFS);
  assign wr_mis_en = wr_en && (addr == MIS_EN_OFS);
  assign wr_tfr_en = wr_en && (addr == TFR_EN_OFS);

  // Idle channels carry stale addresses, so only checked ones count
  assign mis_set = chk_valid & chk.misalign;

  // Set beats a same-cycle clear so no event is lost
  assign next_mis_flags = (mis_flags & ~(wr_mis ? wdata : '0)) |
                          mis_set;
  assign next_tfr_flags = (tfr_flags & ~(wr_tfr ? wdata : '0)) |
                          tfr_done;

  // Summary is combinational, never latched on its own
  assign summary = (mis_flags & mis_en) | (tfr_flags & tfr_en);

  // Read select; unmapped offsets read as zero
  assign rd_sel = (addr == SUMMARY_OFS) ? summary :
                  (addr == MISALIGN_OFS) ? mis_flags :
                  (addr == TFR_OFS) ? tfr_flags :
                  (addr == MIS_EN_OFS) ? mis_en :
                  (addr == TFR_EN_OFS) ? tfr_en : 32'h0000_0000;

  // Mapped offsets, used by the unmapped-read check
  assign rd_hit = (addr == SUMMARY_OFS) || (addr == MISALIGN_OFS) ||
                  (addr == TFR_OFS) || (addr == MIS_EN_OFS) ||
                  (addr == TFR_EN_OFS);

  // ****************************************
  // Flags and enables
  // ****************************************

  // Sticky status flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mis_flags <= FLAGS_RST;
      tfr_flags <= FLAGS_RST;
    end
    else
    begin
      mis_flags <= next_mis_flags;
      tfr_flags <= next_tfr_flags;
    end
  end

  // Interrupt enables, one per flag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mis_en <= EN_RST;
      tfr_en <= EN_RST;
    end
    else
    begin
      if (wr_mis_en)
        mis_en <= wdata;
      if (wr_tfr_en)
        tfr_en <= wdata;
    end
  end

  // ****************************************
  // Read data and interrupt
  // ****************************************

  // Read data stand one cycle only; irq costs one cycle of latency
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= RDATA_RST;
      irq <= 1'b0;
    end
    else
    begin
      rdata <= rd_en ? rd_sel : RDATA_RST;
      irq <= |summary;
    end
  end

  // ****************************************
  // Checks
  // ****************************************

  a_flag_raise: assert property (@(posedge clk) disable iff (!rst_n)
    (mis_set != '0) |=> ((mis_flags & $past(mis_set)) == $past(mis_set)))
    else $error("misaligned channel did not raise its flag");

  a_flag_cause: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> ((mis_flags & ~$past(mis_flags) & ~$past(mis_set)) == '0))
    else $error("misalign flag rose without an error");

  a_w1c_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_mis |=> ((mis_flags & $past(wdata) & ~$past(mis_set)) == '0))
    else $error("written one did not clear a misalign flag");

  a_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_mis |=> ((~mis_flags & $past(mis_flags)) == '0))
    else $error("misalign flag dropped without a clear");

  a_summary_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && (addr == SUMMARY_OFS) |=> (rdata == $past(summary)))
    else $error("summary read returned wrong word");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_en |=> (rdata == 32'h0000_0000))
    else $error("read data stood outside the answer cycle");

  a_summary_live: assert property (@(posedge clk) disable iff (!rst_n)
    ((mis_flags & mis_en) == '0) && ((tfr_flags & tfr_en) == '0)
      |-> (summary == '0))
    else $error("summary held a bit with no unmasked flag");

  a_tfr_feeds: assert property (@(posedge clk) disable iff (!rst_n)
    tfr_done[0] && tfr_en[0] && !wr_tfr_en |=> summary[0])
    else $error("transfer complete did not reach summary");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
    (summary != '0) ##1 (summary != '0) |-> irq)
    else $error("irq low while summary pending");

  // Read back of the flag word, bit for bit
  a_flag_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && (addr == MISALIGN_OFS) |=> (rdata == $past(mis_flags)))
    else $error("misalign flag read returned wrong word");

  // Nothing pending for two cycles must leave irq low
  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (summary == '0) ##1 (summary == '0) |-> !irq)
    else $error("irq high with nothing pending");

  // Top channel at the top bit; catches a reversed bit order
  a_mis_feeds: assert property (@(posedge clk) disable iff (!rst_n)
    mis_flags[31] && mis_en[31] |-> summary[31])
    else $error("misalign flag did not reach summary");

  // ****************************************
  // Register bus checks
  // ****************************************

  // A write to the summary must not land in either enable word
  a_summary_ro: assert property (@(posedge clk) disable iff (!rst_n)
    wr_en && (addr == SUMMARY_OFS)
      |=> (mis_en == $past(mis_en)) && (tfr_en == $past(tfr_en)))
    else $error("write to summary changed a stored word");

  // Unmapped reads answer zero so software never sees stale data
  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
    rd_en && !rd_hit |=> (rdata == 32'h0000_0000))
    else $error("unmapped read returned nonzero data");

  // Transfer-complete flags clear the same way as misalign flags
  a_tfr_clear: assert property (@(posedge clk) disable iff (!rst_n)
    wr_tfr |=> ((tfr_flags & $past(wdata) & ~$past(tfr_done)) == '0))
    else $error("written one did not clear a transfer flag");

endmodule
`default_nettype wire

// ---- logic/dci_pkg.sv ----
// Constants shared by the DMA channel interrupt status block
`default_nettype none
package dci_pkg;
  localparam int NCH = 32;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] SUMMARY_OFS = 12'h020;
  localparam logic [11:0] MISALIGN_OFS = 12'h024;
  localparam logic [11:0] TFR_OFS = 12'h028;
  localparam logic [11:0] MIS_EN_OFS = 12'h02c;
  localparam logic [11:0] TFR_EN_OFS = 12'h030;
  // Item width codes of a channel
  localparam logic [1:0] WIDTH_RSVD = 2'h0;
  localparam logic [1:0] WIDTH_BYTE = 2'h1;
  localparam logic [1:0] WIDTH_HALF = 2'h2;
  localparam logic [1:0] WIDTH_WORD = 2'h3;
  // Values after reset
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] EN_RST = 32'hffff_ffff;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage
`default_nettype wire
